// ---- include/fpfs_pkg.sv ----
// Purpose: shared constants and types of the flag, shadow and subtract block
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes:   instruction word is {high word, low word} in one 32-bit write
package fpfs_pkg;
  // register map, byte offsets
  localparam logic [7:0] OFS_INSN    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_SHD_STS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h10;
  localparam logic [2:0] FREG_PAGE   = 3'h1;
  localparam logic [2:0] SHD_PAGE    = 3'h2;
  localparam int         PAGE_HI     = 7;
  localparam int         PAGE_LO     = 5;
  localparam int         IDX_HI      = 4;
  localparam int         IDX_LO      = 2;
  // status register layout
  localparam int FLG_W      = 11;
  localparam int B_ROUND    = 9;
  localparam int B_TEST     = 6;
  localparam int B_INT_ZERO = 5;
  localparam int B_INT_NEG  = 4;
  localparam int B_FLT_ZERO = 3;
  localparam int B_FLT_NEG  = 2;
  localparam int B_UNDER    = 1;
  localparam int B_OVER     = 0;
  localparam int B_SHADOW   = 31;
  localparam logic [FLG_W-1:0] FLG_LIVE = 11'h27F;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] FREG_RST   = 32'h0000_0000;
  // instruction decode
  localparam logic [9:0]  OPC_FLAG  = 10'b1110011000;
  localparam logic [9:0]  OPC_SAVE  = 10'b1110011001;
  localparam logic [9:0]  OPC_SUBI  = 10'b1110100011;
  localparam logic [15:0] OPC_SUBR  = 16'hE720;
  localparam logic [6:0]  SUBR_ZERO = 7'h00;
  // interrupt status bits
  localparam int IRQ_W     = 3;
  localparam int IRQ_UNDER = 0;
  localparam int IRQ_OVER  = 1;
  localparam int IRQ_SAVE  = 2;
  // single-precision fields
  localparam int FP_SIGN   = 31;
  localparam int FP_EXP_HI = 30;
  localparam int FP_EXP_LO = 23;
  localparam logic [7:0] FP_EXP_MAX = 8'hFF;
  typedef enum logic [4:0] {
    OP_NONE = 5'b00001,
    OP_FLAG = 5'b00010,
    OP_SAVE = 5'b00100,
    OP_SUBR = 5'b01000,
    OP_SUBI = 5'b10000
  } fpfs_op_t;
endpackage

// ---- include/fpfs_sub_if.sv ----
`timescale 1ns/1ps
// Purpose: carrier between the control core and the subtract unit
// Assumes: one clock domain
// Notes:   result and flags are valid for one cycle with valid
interface fpfs_sub_if;
  logic        start;
  logic [31:0] opa;
  logic [31:0] opb;
  logic        round_near;
  logic [31:0] result;
  logic        valid;
  logic        underflow;
  logic        overflow;
  modport client (output start, opa, opb, round_near,
                  input  result, valid, underflow, overflow);
  modport unit   (input  start, opa, opb, round_near,
                  output result, valid, underflow, overflow);
endinterface

// ---- logic/fpfs_flag_merge.sv ----
`timescale 1ns/1ps
// Purpose: masked set or clear of the status flags
// Assumes: mask and value share the status bit layout
// Notes:   purely combinational
module fpfs_flag_merge
  import fpfs_pkg::*;
(
  // flags in and out
  input  wire logic [FLG_W-1:0] flags_i,
  input  wire logic [FLG_W-1:0] mask_i,
  input  wire logic [FLG_W-1:0] value_i,
  output logic      [FLG_W-1:0] flags_o
);
  for (genvar i = 0; i < FLG_W; i++) begin : g_bit
    // reserved positions never change
    if (FLG_LIVE[i]) begin : g_live
      assign flags_o[i] = mask_i[i] ? value_i[i] : flags_i[i];
    end else begin : g_rsvd
      assign flags_o[i] = flags_i[i];
    end
  end
endmodule // fpfs_flag_merge

// ---- logic/fpfs_fsub.sv ----
`timescale 1ns/1ps
// Purpose: single-precision subtract, registered operand stage, combinational result
// Assumes: denormal inputs read as zero, no special case for inf or nan
// Notes:   truncates unless round_near, then adds the guard bit
module fpfs_fsub
  import fpfs_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // request and result
  fpfs_sub_if.unit  sub
);
  logic        go_reg,  go_next;
  logic        rn_reg,  rn_next;
  logic [31:0] a_reg,   a_next;
  logic [31:0] b_reg,   b_next;

  always_comb begin
    go_next = sub.start;
    rn_next = sub.start ? sub.round_near : rn_reg;
    a_next  = sub.start ? sub.opa : a_reg;
    b_next  = sub.start ? sub.opb : b_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      go_reg <= 1'b0;
      rn_reg <= 1'b0;
      a_reg  <= FREG_RST;
      b_reg  <= FREG_RST;
    end else begin
      go_reg <= go_next;
      rn_reg <= rn_next;
      a_reg  <= a_next;
      b_reg  <= b_next;
    end
  end

  always_comb begin
    logic [31:0] x, y, rnd;
    logic [26:0] mx, my, nm;
    logic [27:0] sum;
    logic [7:0]  d;
    logic [4:0]  lz;
    logic [9:0]  e;
    sum = 28'h0;
    e   = 10'h0;
    nm  = 27'h0;
    x = a_reg;
    y = {~b_reg[FP_SIGN], b_reg[FP_SIGN-1:0]};
    // larger magnitude first keeps the difference non-negative
    if (y[FP_SIGN-1:0] > x[FP_SIGN-1:0]) begin
      x = y;
      y = a_reg;
    end
    mx = (x[FP_EXP_HI:FP_EXP_LO] == 8'h00) ? 27'h0 : {1'b1, x[FP_EXP_LO-1:0], 3'b000};
    my = (y[FP_EXP_HI:FP_EXP_LO] == 8'h00) ? 27'h0 : {1'b1, y[FP_EXP_LO-1:0], 3'b000};
    d  = x[FP_EXP_HI:FP_EXP_LO] - y[FP_EXP_HI:FP_EXP_LO];
    my = (d > 8'd26) ? 27'h0 : (my >> d);
    if (x[FP_SIGN] == y[FP_SIGN]) sum = {1'b0, mx} + {1'b0, my};
    else sum = {1'b0, mx} - {1'b0, my};
    lz = 5'd0;
    for (int i = 0; i < 27; i++) begin
      if (sum[i]) lz = 5'(26 - i);
    end
    if (sum[27]) begin
      nm = sum[27:1];
      e  = {2'b00, x[FP_EXP_HI:FP_EXP_LO]} + 10'd1;
    end else begin
      nm = 27'(sum[26:0] << lz);
      e  = {2'b00, x[FP_EXP_HI:FP_EXP_LO]} - {5'b0, lz};
    end
    rnd = {x[FP_SIGN], e[7:0], nm[25:3]} + {31'h0, rn_reg & nm[2]};
    sub.underflow = 1'b0;
    sub.overflow  = 1'b0;
    if (sum == 28'h0) begin
      sub.result = 32'h0;
    end else if (e[9] || e == 10'h0) begin
      sub.result    = {x[FP_SIGN], 31'h0};
      sub.underflow = go_reg;
    end else if (e >= {2'b00, FP_EXP_MAX} || rnd[FP_EXP_HI:FP_EXP_LO] == FP_EXP_MAX) begin
      sub.result   = {x[FP_SIGN], FP_EXP_MAX, 23'h0};
      sub.overflow = go_reg;
    end else begin
      sub.result = rnd;
    end
  end

  assign sub.valid = go_reg;

endmodule // fpfs_fsub

// ---- logic/fpfs_top.sv ----
`timescale 1ns/1ps
// Purpose: float unit slice - flag write, shadow store and subtract
// Assumes: instructions arrive as register writes over classic Wishbone
// Notes:   one clock, synchronous active-high reset
module fpfs_top
  import fpfs_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // status view and interrupt
  output logic      [31:0] status_o,
  output logic             irq_o
);
  localparam int NREG = 8;

  fpfs_sub_if sub ();

  logic [31:0]      freg_reg   [NREG];
  logic [31:0]      freg_next  [NREG];
  logic [31:0]      shadow_reg [NREG];
  logic [31:0]      shadow_next[NREG];
  logic [31:0]      status_reg,  status_next;
  logic [31:0]      shd_sts_reg, shd_sts_next;
  logic [31:0]      insn_reg,    insn_next;
  logic [IRQ_W-1:0] irq_sts_reg, irq_sts_next;
  logic [IRQ_W-1:0] irq_msk_reg, irq_msk_next;
  logic [2:0]       dest_reg,    dest_next;
  logic [31:0]      rdata_reg,   rdata_next;
  logic             ack_reg,     ack_next;

  logic             req;
  logic             wr;
  logic [31:0]      wmask;
  logic [2:0]       idx;
  logic [2:0]       page;
  logic             issue;
  fpfs_op_t         op;
  logic [15:0]      lo_w;
  logic [15:0]      hi_w;
  logic [FLG_W-1:0] flg_mask;
  logic [FLG_W-1:0] flg_value;
  logic [FLG_W-1:0] flg_merged;
  logic [IRQ_W-1:0] irq_event;

  // bus decode
  assign req  = cyc_i & stb_i;
  // writes land on the edge where the master sees ack
  assign wr   = req & we_i & ack_reg;
  assign idx  = adr_i[IDX_HI:IDX_LO];
  assign page = adr_i[PAGE_HI:PAGE_LO];
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  // a partial write cannot form a whole instruction, so it is ignored
  assign issue = wr & (adr_i == OFS_INSN) & (sel_i == 4'hF);

  // instruction decode
  assign lo_w = dat_i[15:0];
  assign hi_w = dat_i[31:16];

  always_comb begin
    op = OP_NONE;
    if (issue) begin
      if (lo_w[15:6] == OPC_FLAG) begin
        op = OP_FLAG;
      end else if (lo_w[15:6] == OPC_SAVE) begin
        op = OP_SAVE;
      end else if (lo_w == OPC_SUBR && hi_w[15:9] == SUBR_ZERO) begin
        op = OP_SUBR;
      end else if (lo_w[15:6] == OPC_SUBI) begin
        op = OP_SUBI;
      end
    end
  end

  // mask low bits from the low word, high bits from the high word
  assign flg_mask  = {hi_w[15:11], lo_w[5:0]};
  assign flg_value = hi_w[10:0];

  fpfs_flag_merge u_merge (
    .flags_i (status_reg[FLG_W-1:0]),
    .mask_i  (flg_mask),
    .value_i (flg_value),
    .flags_o (flg_merged)
  );

  // subtract launch
  always_comb begin
    sub.start      = 1'b0;
    sub.opa        = freg_reg[hi_w[5:3]];
    sub.opb        = freg_reg[hi_w[8:6]];
    sub.round_near = status_reg[B_ROUND];
    if (op == OP_SUBR) begin
      sub.start = 1'b1;
    end else if (op == OP_SUBI) begin
      sub.start = 1'b1;
      sub.opa   = {hi_w, 16'h0000};
      sub.opb   = freg_reg[lo_w[5:3]];
    end
  end

  fpfs_fsub u_fsub (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sub   (sub)
  );

  always_comb begin
    dest_next = dest_reg;
    if (op == OP_SUBR) begin
      dest_next = hi_w[2:0];
    end else if (op == OP_SUBI) begin
      dest_next = lo_w[2:0];
    end
  end

  // working register file
  always_comb begin
    freg_next = freg_reg;
    if (wr && page == FREG_PAGE) begin
      freg_next[idx] = (freg_reg[idx] & ~wmask) | (dat_i & wmask);
    end
    // writeback wins; a clashing bus write is a program fault
    if (sub.valid) begin
      freg_next[dest_reg] = sub.result;
    end
  end

  // shadow set captures current values, before this edge's updates
  always_comb begin
    shadow_next  = shadow_reg;
    shd_sts_next = shd_sts_reg;
    if (op == OP_SAVE) begin
      shadow_next  = freg_reg;
      shd_sts_next = status_reg;
    end
  end

  // status register
  always_comb begin
    status_next = status_reg;
    if (op == OP_FLAG || op == OP_SAVE) begin
      status_next[FLG_W-1:0] = flg_merged;
    end
    if (op == OP_SAVE) begin
      status_next[B_SHADOW] = 1'b1;
    end
    // latched flags only ever set here, so a same-edge flag write loses
    if (sub.underflow) begin
      status_next[B_UNDER] = 1'b1;
    end
    if (sub.overflow) begin
      status_next[B_OVER] = 1'b1;
    end
  end

  always_comb begin
    insn_next = insn_reg;
    if (issue) begin
      insn_next = dat_i;
    end
  end

  // interrupt status, write one to clear, new event beats the clear
  always_comb begin
    irq_event            = '0;
    irq_event[IRQ_UNDER] = sub.underflow;
    irq_event[IRQ_OVER]  = sub.overflow;
    irq_event[IRQ_SAVE]  = (op == OP_SAVE);
    irq_sts_next = irq_sts_reg;
    irq_msk_next = irq_msk_reg;
    if (wr && adr_i == OFS_IRQ_STS) begin
      irq_sts_next = irq_sts_reg & ~(dat_i[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
    end else if (wr && adr_i == OFS_IRQ_MSK) begin
      irq_msk_next = (irq_msk_reg & ~wmask[IRQ_W-1:0])
                   | (dat_i[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
    end
    irq_sts_next = irq_sts_next | irq_event;
  end

  // ack one cycle after the request, then drop for a cycle
  always_comb begin
    ack_next   = req & ~ack_reg;
    rdata_next = rdata_reg;
    if (req && !ack_reg) begin
      if (adr_i == OFS_INSN) begin
        rdata_next = insn_reg;
      end else if (adr_i == OFS_STATUS) begin
        rdata_next = status_reg;
      end else if (adr_i == OFS_SHD_STS) begin
        rdata_next = shd_sts_reg;
      end else if (adr_i == OFS_IRQ_STS) begin
        rdata_next = {{(32-IRQ_W){1'b0}}, irq_sts_reg};
      end else if (adr_i == OFS_IRQ_MSK) begin
        rdata_next = {{(32-IRQ_W){1'b0}}, irq_msk_reg};
      end else if (page == FREG_PAGE) begin
        rdata_next = freg_reg[idx];
      end else if (page == SHD_PAGE) begin
        rdata_next = shadow_reg[idx];
      end else begin
        // unmapped reads answer zero, writes are dropped
        rdata_next = 32'h0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NREG; i++) begin
        freg_reg[i]   <= FREG_RST;
        shadow_reg[i] <= FREG_RST;
      end
      status_reg  <= STATUS_RST;
      shd_sts_reg <= STATUS_RST;
      insn_reg    <= 32'h0;
      irq_sts_reg <= '0;
      irq_msk_reg <= '0;
      dest_reg    <= 3'h0;
      rdata_reg   <= 32'h0;
      ack_reg     <= 1'b0;
    end else begin
      freg_reg    <= freg_next;
      shadow_reg  <= shadow_next;
      status_reg  <= status_next;
      shd_sts_reg <= shd_sts_next;
      insn_reg    <= insn_next;
      irq_sts_reg <= irq_sts_next;
      irq_msk_reg <= irq_msk_next;
      dest_reg    <= dest_next;
      rdata_reg   <= rdata_next;
      ack_reg     <= ack_next;
    end
  end

  assign dat_o    = rdata_reg;
  assign ack_o    = ack_reg;
  assign status_o = status_reg;
  assign irq_o    = |(irq_sts_reg & irq_msk_reg);

endmodule // fpfs_top

// ---- verification/fpfs_assertions.sv ----
// Purpose: port-level checks of the flag, shadow and subtract slice
// Assumes: an instruction write takes effect at the edge that sees ack
// Notes:   bound to fpfs_top
`timescale 1ns/1ps
module fpfs_checker
  import fpfs_pkg::*;
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0]  sel_i,
  input wire logic        we_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // status and interrupt
  input wire logic [31:0] status_o,
  input wire logic        irq_o
);
  logic             ins_w, flg_w, sav_w, sub_w, rdsh_w;
  logic [FLG_W-1:0] msk_w, val_w;
  logic [31:0]      shd_reg;
  assign ins_w  = cyc_i & stb_i & we_i & ack_o & (adr_i == OFS_INSN) & (sel_i == 4'hF);
  assign flg_w  = ins_w & (dat_i[15:6] == OPC_FLAG);
  assign sav_w  = ins_w & (dat_i[15:6] == OPC_SAVE);
  assign sub_w  = ins_w & ((dat_i[15:0] == OPC_SUBR && dat_i[31:25] == SUBR_ZERO)
                  || dat_i[15:6] == OPC_SUBI);
  assign rdsh_w = cyc_i & stb_i & !we_i & ack_o & (adr_i == OFS_SHD_STS);
  assign msk_w  = {dat_i[31:27], dat_i[5:0]} & FLG_LIVE;
  assign val_w  = dat_i[26:16];
  // expected shadow status: live status just before the save edge
  always_ff @(posedge clk_i) begin
    if (rst_i)
      shd_reg <= STATUS_RST;
    else if (sav_w)
      shd_reg <= status_o;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_keep;
    flg_w || sav_w |=> ((status_o[10:0] ^ $past(status_o[10:0])) & ~$past(msk_w)) == 11'h000;
  endproperty
  a_keep: assert property (p_keep) else $error("unmasked flag changed");
  property p_load;
    flg_w || sav_w |=> ((status_o[10:0] ^ $past(val_w)) & $past(msk_w)) == 11'h000;
  endproperty
  a_load: assert property (p_load) else $error("masked flag not loaded");
  property p_flag_mode;
    flg_w |=> $stable(status_o[B_SHADOW]);
  endproperty
  a_flag_mode: assert property (p_flag_mode) else $error("flag write moved shadow mode");
  property p_shadow;
    sav_w |=> status_o[B_SHADOW];
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow mode not set");
  property p_shd_sts;
    rdsh_w |-> dat_o == shd_reg;
  endproperty
  a_shd_sts: assert property (p_shd_sts) else $error("shadow status wrong");
  property p_sub_only;
    sub_w |=> ($stable(status_o[31:2]) && (~status_o[1:0] & $past(status_o[1:0])) == 2'h0) [*2];
  endproperty
  a_sub_only: assert property (p_sub_only) else $error("subtract touched other flags");
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    $rose(ack_o) |-> $past(cyc_i & stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_rst;
    $fell(rst_i) |-> status_o == STATUS_RST && !ack_o && !irq_o;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  c_save: cover property (sav_w);
  c_sub: cover property (sub_w);
  c_irq: cover property ($rose(irq_o));
endmodule // fpfs_checker

bind fpfs_top fpfs_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
  .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .dat_o(dat_o), .ack_o(ack_o), .status_o(status_o), .irq_o(irq_o));

// ---- verification/testbench.sv ----
// Purpose: self-checking bench of the flag, shadow and subtract slice
// Assumes: reads are scored by a monitor from a queue of expectations
// Notes:   float cases are exact apart from one guard-bit rounding case
`timescale 1ns/1ps
module testbench;
  import fpfs_pkg::*;
  typedef struct { string nm; logic [31:0] v; } fpfs_exp_t;
  logic        clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_o, status_o, seed, sts, shd, r;
  logic [31:0] fr [8];
  logic [10:0] mk;
  logic        ack_o, irq_o;
  int          miscompares = 0, compares = 0;
  fpfs_exp_t   q [$];
  fpfs_exp_t   x;
  fpfs_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
    .ack_o(ack_o), .status_o(status_o), .irq_o(irq_o));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [31:0] fl(input logic [9:0] op, input logic [10:0] m, input logic [10:0] v);
    return {m[10:6], v, op, m[5:0]};
  endfunction
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // request held until the edge that samples ack, released by nba there
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    adr_i <= a;
    we_i  <= w;
    dat_i <= d;
    sel_i <= 4'hF;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    q.push_back('{nm, e});
    wb(a, 1'b0, 32'h0000_0000);
  endtask
  task flag(input logic [9:0] op, input logic [10:0] m, input logic [10:0] v);
    wb(OFS_INSN, 1'b1, fl(op, m, v));
    sts[10:0] = (sts[10:0] & ~(m & FLG_LIVE)) | (v & m & FLG_LIVE);
  endtask
  task irq_is(input logic e);
    @(negedge clk_i);
    check("irq", {31'h0, e}, {31'h0, irq_o});
  endtask
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && cyc_i === 1'b1 && we_i === 1'b0) begin
      if (q.size() > 0) begin
        x = q.pop_front();
      end else begin
        x = '{"unexpected read", 32'h0};
      end
      check(x.nm, x.v, dat_o);
    end
  end
  initial begin
    repeat (2000) @(posedge clk_i);
    miscompares++;
    final_report();
  end
  initial begin
    seed = 32'h7C97;
    sts = STATUS_RST;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_STATUS, sts, "status at reset");
    irq_is(1'b0);
    for (int i = 0; i < 8; i++) begin
      fr[i] = rnd();
      wb(8'h20 + 8'(4 * i), 1'b1, fr[i]);
    end
    for (int i = 0; i < 8; i++) rd(8'h20 + 8'(4 * i), fr[i], "float reg");
    // first pass only touches reserved positions, second every position
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      mk = (i == 0) ? 11'h580 : ((i == 1) ? 11'h7FF : r[10:0]);
      flag(OPC_FLAG, mk, r[26:16]);
      rd(OFS_STATUS, sts, "status flags");
    end
    shd = sts;
    flag(OPC_SAVE, 11'h7FF, 11'h000);
    sts[B_SHADOW] = 1'b1;
    rd(OFS_SHD_STS, shd, "shadow status");
    rd(OFS_STATUS, sts, "status after save");
    for (int i = 0; i < 8; i++) rd(8'h40 + 8'(4 * i), fr[i], "shadow reg");
    wb(OFS_IRQ_STS, 1'b1, 32'h0000_0007);
    wb(8'h24, 1'b1, 32'h4040_0000);
    wb(8'h28, 1'b1, 32'h3F80_0000);
    wb(OFS_INSN, 1'b1, {7'h00, 3'h2, 3'h1, 3'h0, OPC_SUBR});
    rd(8'h20, 32'h4000_0000, "register subtract");
    rd(8'h40, fr[0], "shadow reg kept");
    wb(8'h2C, 1'b1, 32'h3F00_0000);
    wb(OFS_INSN, 1'b1, {16'h4000, OPC_SUBI, 3'h3, 3'h4});
    rd(8'h30, 32'h3FC0_0000, "immediate subtract");
    rd(OFS_STATUS, sts, "status after subtract");
    wb(8'h34, 1'b1, 32'h7F00_0000);
    wb(8'h38, 1'b1, 32'hFF00_0000);
    wb(OFS_INSN, 1'b1, {7'h00, 3'h6, 3'h5, 3'h7, OPC_SUBR});
    sts[B_OVER] = 1'b1;
    rd(8'h3C, 32'h7F80_0000, "overflow result");
    rd(OFS_STATUS, sts, "status overflow");
    rd(OFS_IRQ_STS, 32'h0000_0002, "irq status");
    irq_is(1'b0);
    wb(OFS_IRQ_MSK, 1'b1, 32'h0000_0002);
    irq_is(1'b1);
    wb(OFS_IRQ_STS, 1'b1, 32'h0000_0002);
    irq_is(1'b0);
    // result below the smallest normal flushes to zero
    wb(8'h24, 1'b1, 32'h0080_0000);
    wb(8'h28, 1'b1, 32'h00C0_0000);
    wb(OFS_INSN, 1'b1, {7'h00, 3'h2, 3'h1, 3'h3, OPC_SUBR});
    sts[B_UNDER] = 1'b1;
    rd(OFS_STATUS, sts, "status underflow");
    rd(OFS_IRQ_STS, 32'h0000_0001, "irq underflow");
    flag(OPC_FLAG, 11'h003, 11'h000);
    rd(OFS_STATUS, sts, "latched flags cleared");
    // round mode on: 1.0 minus 2^-25 rounds up to 1.0 instead of truncating
    flag(OPC_FLAG, 11'h200, 11'h200);
    wb(8'h20, 1'b1, 32'h3F80_0000);
    wb(8'h24, 1'b1, 32'h3300_0000);
    wb(OFS_INSN, 1'b1, {7'h00, 3'h1, 3'h0, 3'h2, OPC_SUBR});
    rd(8'h28, 32'h3F80_0000, "rounded subtract");
    rd(OFS_INSN, {7'h00, 3'h1, 3'h0, 3'h2, OPC_SUBR}, "last instruction");
    wb(8'h7C, 1'b1, rnd());
    rd(8'h7C, 32'h0000_0000, "unmapped read");
    wb(OFS_STATUS, 1'b1, 32'hFFFF_FFFF);
    rd(OFS_STATUS, sts, "status read only");
    @(posedge clk_i);
    final_report();
  end
endmodule // testbench
